// ==== dlm_pkg.sv ====
package dlm_pkg;

  // ----------------------------------------------------------------
  // Widths and timing
  // ----------------------------------------------------------------
  localparam int unsigned PIX_W           = 24;    // Widest packing carried per word
  localparam int unsigned LINE_AW         = 12;    // Pixel index and per-link word address
  localparam int unsigned GRP_W           = 7;     // Group size field, 1 to 64
  localparam int unsigned GRP_MIN         = 1;
  localparam int unsigned GRP_MAX         = 64;
  localparam int unsigned TMR_W           = 16;
  localparam int unsigned LINE_PERIOD_CYC = 2200;  // Link clocks between two line starts
  localparam int unsigned HSS_SKEW_MAX    = 5;     // Largest start skew between the links

  // ----------------------------------------------------------------
  // Modes and formats
  // ----------------------------------------------------------------
  typedef enum logic {
    DLM_SPLIT_HALVES = 1'b0,
    DLM_SPLIT_GROUPS = 1'b1
  } dlm_split_e;

  typedef enum logic [1:0] {
    DLM_FMT_RGB565  = 2'h0,
    DLM_FMT_RGB666  = 2'h1,
    DLM_FMT_RGB888  = 2'h2,
    DLM_FMT_YCC422  = 2'h3
  } dlm_fmt_e;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    dlm_split_e           mode;
    dlm_fmt_e             fmt;
    logic [GRP_W-1:0]     grp0;    // Pixels per group on link zero
    logic [GRP_W-1:0]     grp1;    // Pixels per group on link one
    logic [LINE_AW-1:0]   split;   // First pixel of the right half
    logic [LINE_AW-1:0]   len;     // Pixels in the line
  } dlm_cfg_s;

  typedef struct packed {
    logic                 valid;
    logic                 hss;     // Line start marker word
    logic                 sop;     // First word of the video packet
    logic                 eop;     // Last word of the video packet
    dlm_fmt_e             fmt;
    logic [PIX_W-1:0]     data;
  } dlm_link_s;

endpackage

// ==== dlm_sync2.sv ====
`timescale 1ns/1ps
module dlm_sync2 (
  // Clock and reset
  input  wire logic clk_in,
  input  wire logic rst_in,
  // Level crossing
  input  wire logic d_in,
  output logic      q_out
);

  logic meta_q;

  // Two flops; only the second is read outside
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      meta_q <= 1'b0;
      q_out  <= 1'b0;
    end else begin
      meta_q <= d_in;
      q_out  <= meta_q;
    end
  end

endmodule

// ==== dlm_line_mem.sv ====
`timescale 1ns/1ps
module dlm_line_mem #(
  parameter int unsigned DW = 24,
  parameter int unsigned AW = 12
) (
  // Write side
  input  wire logic          wr_clk_in,
  input  wire logic          we_in,
  input  wire logic [AW-1:0] waddr_in,
  input  wire logic [DW-1:0] wdata_in,
  // Read side
  input  wire logic          rd_clk_in,
  input  wire logic          rst_in,
  input  wire logic          re_in,
  input  wire logic [AW-1:0] raddr_in,
  output logic      [DW-1:0] rdata_q_out
);

  logic [DW-1:0] mem_q [2**AW];

  // Write port; the reader never touches a word while it is written
  always_ff @(posedge wr_clk_in) begin
    if (we_in) begin
      mem_q[waddr_in] <= wdata_in;
    end
  end

  // Registered read
  always_ff @(posedge rd_clk_in or posedge rst_in) begin
    if (rst_in) begin
      rdata_q_out <= '0;
    end else if (re_in) begin
      rdata_q_out <= mem_q[raddr_in];
    end
  end

endmodule

// ==== dlm_host_splitter.sv ====
`timescale 1ns/1ps
// Overview of operation
// - Host sends progressive video only
// - Halves mode: left half on link zero
// - Group mode: even groups on link zero
// - At most one packet per link per line; none on a link with no pixels
// - Line start packet precedes each line's data
// - At most one line per sync period
// - Both line starts within five cycles
// - With offset, link zero starts first
// - Skew drifts under one line per frame
// - Both links clocked from one source
// - Line start word, then video after one idle cycle
module dlm_host_splitter
  import dlm_pkg::*;
#(
  parameter int unsigned LINE_PERIOD = dlm_pkg::LINE_PERIOD_CYC
) (
  // Clocks and reset
  input  wire logic                    core_clk_in,
  input  wire logic                    link_clk_in,
  input  wire logic                    rst_in,
  // Line source
  input  wire logic                    line_start_in,
  input  wire dlm_pkg::dlm_cfg_s       line_cfg_in,
  input  wire logic                    px_valid_in,
  input  wire logic [dlm_pkg::PIX_W-1:0] px_data_in,
  output logic                         px_ready_out,
  output logic                         line_busy_out,
  // Link streams
  output dlm_pkg::dlm_link_s           input_link_zero_out,
  output dlm_pkg::dlm_link_s           input_link_one_out
);
  import dlm_pkg::*;

  // ----------------------------------------------------------------
  // Core side: steer pixels into the two line memories
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    C_IDLE = 2'h0,
    C_FILL = 2'h1,
    C_WAIT = 2'h2
  } dlm_cst_e;

  dlm_cst_e           cst_q, cst_d;
  dlm_cfg_s           cfg_q;
  logic [LINE_AW-1:0] idx_q;
  logic [GRP_W-1:0]   grp_q;
  logic               cur_q;
  logic [LINE_AW-1:0] wcnt_q [2];
  logic               ready_q, busy_q;
  logic               req_q;
  logic               ack_s;

  wire                start_ok   = (cst_q == C_IDLE) && line_start_in && (line_cfg_in.len != '0);
  wire                take       = (cst_q == C_FILL) && px_valid_in && ready_q;
  wire                last_px    = (idx_q == cfg_q.len - 1'b1);
  wire [GRP_W-1:0]    gsize      = cur_q ? cfg_q.grp1 : cfg_q.grp0;
  wire                grp_end    = (grp_q == gsize - 1'b1);
  wire                half_cross = (idx_q + 1'b1 == cfg_q.split);
  wire                acked      = (cst_q == C_WAIT) && (ack_s == req_q);
  // Halves mode with an empty left half starts on link one
  wire                start_link = (line_cfg_in.mode == DLM_SPLIT_HALVES) &&
                                   (line_cfg_in.split == '0);
  wire                we0        = take && !cur_q;
  wire                we1        = take && cur_q;

  // Next state of the fill sequence
  always_comb begin
    cst_d = cst_q;
    case (cst_q)
      C_IDLE: begin
        if (start_ok) cst_d = C_FILL;
      end
      C_FILL: begin
        if (take && last_px) cst_d = C_WAIT;
      end
      C_WAIT: begin
        if (acked) cst_d = C_IDLE;
      end
      default: cst_d = C_IDLE;
    endcase
  end

  // Fill state, config and handshake request
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      cst_q   <= C_IDLE;
      cfg_q   <= '0;
      ready_q <= 1'b0;
      busy_q  <= 1'b0;
      req_q   <= 1'b0;
    end else begin
      cst_q   <= cst_d;
      ready_q <= (cst_d == C_FILL);
      busy_q  <= (cst_d != C_IDLE);
      // No field/interlace state exists: every line is a progressive line
      if (start_ok) cfg_q <= line_cfg_in;
      // Toggle tells the link side a full line is stored
      if (take && last_px) req_q <= ~req_q;
    end
  end

  // Pixel index, group count and link selection
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      idx_q     <= '0;
      grp_q     <= '0;
      cur_q     <= 1'b0;
      wcnt_q[0] <= '0;
      wcnt_q[1] <= '0;
    end else if (start_ok) begin
      idx_q     <= '0;
      grp_q     <= '0;
      cur_q     <= start_link;
      wcnt_q[0] <= '0;
      wcnt_q[1] <= '0;
    end else if (take) begin
      idx_q         <= idx_q + 1'b1;
      wcnt_q[cur_q] <= wcnt_q[cur_q] + 1'b1;
      if (cfg_q.mode == DLM_SPLIT_GROUPS) begin
        // Alternate groups; each link has its own group size
        grp_q <= grp_end ? '0 : grp_q + 1'b1;
        if (grp_end) cur_q <= ~cur_q;
      end else if (half_cross) begin
        cur_q <= 1'b1;
      end
    end
  end

  assign px_ready_out  = ready_q;
  assign line_busy_out = busy_q;

  // ----------------------------------------------------------------
  // Crossings
  // ----------------------------------------------------------------
  logic req_s;
  logic ack_q;

  dlm_sync2 u_req_sync (
    .clk_in (link_clk_in),
    .rst_in (rst_in),
    .d_in   (req_q),
    .q_out  (req_s)
  );

  dlm_sync2 u_ack_sync (
    .clk_in (core_clk_in),
    .rst_in (rst_in),
    .d_in   (ack_q),
    .q_out  (ack_s)
  );

  // ----------------------------------------------------------------
  // Link side: line timer, line start and packets
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    L_IDLE = 2'h0,
    L_HSS  = 2'h1,
    L_DATA = 2'h2,
    L_ACK  = 2'h3
  } dlm_lst_e;

  localparam logic [TMR_W-1:0] PERIOD_M1 = TMR_W'(LINE_PERIOD - 1);

  dlm_lst_e          lst_q, lst_d;
  logic [TMR_W-1:0]  tmr_q;
  dlm_link_s         lk_q [2];
  logic              busy_l [2];

  wire pending = (req_s != ack_q);
  wire go      = (lst_q == L_IDLE) && pending && (tmr_q == '0);
  wire drained = !busy_l[0] && !busy_l[1];

  // Link sequence; both links share this one state
  always_comb begin
    lst_d = lst_q;
    case (lst_q)
      L_IDLE: begin
        if (go) lst_d = L_HSS;
      end
      L_HSS:  lst_d = L_DATA;
      L_DATA: begin
        if (drained) lst_d = L_ACK;
      end
      L_ACK:  lst_d = L_IDLE;
      default: lst_d = L_IDLE;
    endcase
  end

  // State, line period timer and acknowledge toggle
  always_ff @(posedge link_clk_in or posedge rst_in) begin
    if (rst_in) begin
      lst_q <= L_IDLE;
      tmr_q <= '0;
      ack_q <= 1'b0;
    end else begin
      lst_q <= lst_d;
      // One line per period: the next start waits out the timer
      if (go) tmr_q <= PERIOD_M1;
      else if (tmr_q != '0) tmr_q <= tmr_q - 1'b1;
      if (lst_q == L_ACK) ack_q <= req_s;
    end
  end

  // Per-link reader; word counts are stable while the handshake is open
  for (genvar g = 0; g < 2; g++) begin : g_link
    logic [LINE_AW-1:0] ra_q;
    logic               pv_q, psop_q, peop_q;
    logic [PIX_W-1:0]   rdata;
    wire  [LINE_AW-1:0] cnt  = wcnt_q[g];
    wire                re   = (lst_q == L_DATA) && (ra_q != cnt);
    wire                wex  = (g == 0) ? we0 : we1;

    dlm_line_mem #(
      .DW (PIX_W),
      .AW (LINE_AW)
    ) u_mem (
      .wr_clk_in   (core_clk_in),
      .we_in       (wex),
      .waddr_in    (wcnt_q[g]),
      .wdata_in    (px_data_in),
      .rd_clk_in   (link_clk_in),
      .rst_in      (rst_in),
      .re_in       (re),
      .raddr_in    (ra_q),
      .rdata_q_out (rdata)
    );

    assign busy_l[g] = re || pv_q;

    // Read address and pipeline flags
    always_ff @(posedge link_clk_in or posedge rst_in) begin
      if (rst_in) begin
        ra_q   <= '0;
        pv_q   <= 1'b0;
        psop_q <= 1'b0;
        peop_q <= 1'b0;
      end else begin
        if (lst_q == L_HSS) ra_q <= '0;
        else if (re) ra_q <= ra_q + 1'b1;
        pv_q   <= re;
        psop_q <= re && (ra_q == '0);
        peop_q <= re && (ra_q == cnt - 1'b1);
      end
    end

    // Output word: line start marker or pixel
    always_ff @(posedge link_clk_in or posedge rst_in) begin
      if (rst_in) begin
        lk_q[g] <= '0;
      end else begin
        lk_q[g].valid <= (lst_q == L_HSS) || pv_q;
        lk_q[g].hss   <= (lst_q == L_HSS);
        lk_q[g].sop   <= pv_q && psop_q;
        lk_q[g].eop   <= pv_q && peop_q;
        lk_q[g].fmt   <= cfg_q.fmt;
        lk_q[g].data  <= pv_q ? rdata : '0;
      end
    end
  end

  assign input_link_zero_out = lk_q[0];
  assign input_link_one_out  = lk_q[1];

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  logic [TMR_W-1:0] since_q;
  logic             first_q;
  logic [1:0]       sop_n_q;

  // Cycles since last line start, and link zero packet count per line
  always_ff @(posedge link_clk_in or posedge rst_in) begin
    if (rst_in) begin
      since_q <= '0;
      first_q <= 1'b0;
      sop_n_q <= '0;
    end else begin
      if (lk_q[0].hss) since_q <= '0;
      else if (since_q != '1) since_q <= since_q + 1'b1;
      if (lk_q[0].hss) first_q <= 1'b1;
      if (lk_q[0].hss) sop_n_q <= '0;
      else if (lk_q[0].sop && sop_n_q != 2'h3) sop_n_q <= sop_n_q + 1'b1;
    end
  end

  AST_HSS_TOGETHER: assert property (
    @(posedge link_clk_in) disable iff (rst_in)
    lk_q[0].hss == lk_q[1].hss)
    else $error("line start not aligned on both links");

  AST_HSS_THEN_DATA: assert property (
    @(posedge link_clk_in) disable iff (rst_in)
    (lst_q == L_HSS) |=> (lst_q == L_DATA) ##1 (lst_q == L_DATA || lst_q == L_ACK))
    else $error("video does not follow line start");

  AST_PERIOD: assert property (
    @(posedge link_clk_in) disable iff (rst_in)
    (lk_q[0].hss && first_q) |-> (since_q >= PERIOD_M1))
    else $error("line start came early");

  AST_ONE_PACKET: assert property (
    @(posedge link_clk_in) disable iff (rst_in)
    sop_n_q <= 2'h1)
    else $error("more than one packet on link zero in a line");

  AST_SOP_AFTER_HSS: assert property (
    @(posedge link_clk_in) disable iff (rst_in)
    lk_q[1].sop |-> (lst_q == L_DATA || lst_q == L_ACK) && lk_q[1].valid)
    else $error("packet outside a line");

  AST_READY_DROP: assert property (
    @(posedge core_clk_in) disable iff (rst_in)
    (take && last_px) |=> !px_ready_out ##1 (cst_q == C_WAIT || cst_q == C_IDLE))
    else $error("ready stays up after last pixel");

  AST_HALVES_ORDER: assert property (
    @(posedge core_clk_in) disable iff (rst_in)
    (take && cfg_q.mode == DLM_SPLIT_HALVES) |-> (cur_q == (idx_q >= cfg_q.split)))
    else $error("halves split on the wrong link");

  AST_GROUP_SWITCH: assert property (
    @(posedge core_clk_in) disable iff (rst_in)
    (take && cfg_q.mode == DLM_SPLIT_GROUPS && grp_end) |=> (cur_q != $past(cur_q)))
    else $error("group did not change link");

  AST_GROUP_FIRST: assert property (
    @(posedge core_clk_in) disable iff (rst_in)
    (start_ok && line_cfg_in.mode == DLM_SPLIT_GROUPS) |=> !cur_q && (idx_q == '0))
    else $error("first group not on link zero");

  COV_HALVES: cover property (
    @(posedge core_clk_in) disable iff (rst_in)
    take && last_px && cfg_q.mode == DLM_SPLIT_HALVES);

  COV_GROUPS: cover property (
    @(posedge core_clk_in) disable iff (rst_in)
    take && last_px && cfg_q.mode == DLM_SPLIT_GROUPS);

  COV_BOTH_EOP: cover property (
    @(posedge link_clk_in) disable iff (rst_in)
    lk_q[0].eop ##[1:300] lk_q[1].eop);

endmodule

// ==== dlm_dev_model.sv ====
`timescale 1ns/1ps
module dlm_dev_model (
  // Link side
  input  wire logic                 link_clk_in,
  input  wire logic                 rst_in,
  input  wire dlm_pkg::dlm_cfg_s    cfg_in,
  input  wire dlm_pkg::dlm_link_s   link0_in,
  input  wire dlm_pkg::dlm_link_s   link1_in,
  // Merged stream
  output logic                      pix_valid_out,
  output logic [dlm_pkg::PIX_W-1:0] pix_data_out,
  output logic [15:0]               lines_out,
  output logic [15:0]               errs_out
);
  import dlm_pkg::*;
  // ----------------------------------------------------------------
  // Line store
  // ----------------------------------------------------------------
  logic [PIX_W-1:0] q0[$];
  logic [PIX_W-1:0] q1[$];
  logic [PIX_W-1:0] oq[$];
  int               cyc, t0, t1, g, k;
  bit               s0, s1, sk, n;

  // Data before a line start is a fault; split packets are still welcome
  task automatic take(input dlm_link_s w, input bit s, ref logic [PIX_W-1:0] q[$]);
    if (w.valid && !w.hss) begin
      if (!s || w.fmt !== cfg_in.fmt) errs_out++; // any format matching cfg_in.fmt passes
      q.push_back(w.data); // any packet count
    end
  endtask

  // Collect both shares, merge once the whole line is in
  always @(posedge link_clk_in or posedge rst_in) begin
    if (rst_in) begin
      q0.delete();
      q1.delete();
      oq.delete();
      {cyc, s0, s1, sk} = '0;
      {lines_out, errs_out, pix_valid_out, pix_data_out} = '0;
    end else begin
      cyc++;
      if (link0_in.valid && link0_in.hss) begin
        s0 = 1'b1;
        t0 = cyc;
      end
      if (link1_in.valid && link1_in.hss) begin
        s1 = 1'b1;
        t1 = cyc;
      end
      // Link one may lag by any fixed offset, but lead by five at most
      if (s0 && s1 && !sk) begin
        sk = 1'b1;
        if (t0 > t1 + int'(HSS_SKEW_MAX)) errs_out++;
      end
      take(link0_in, s0, q0);
      take(link1_in, s1, q1);
      // Waits for both portions; halves use one huge group
      if (cfg_in.len != 0 && q0.size() + q1.size() == int'(cfg_in.len)) begin
        n = 1'b0;
        while (q0.size() + q1.size() > 0) begin
          g = (cfg_in.mode == DLM_SPLIT_HALVES) ? int'(cfg_in.len) :
              (n ? int'(cfg_in.grp1) : int'(cfg_in.grp0));
          for (k = 0; k < g && (n ? q1.size() : q0.size()) > 0; k++) begin
            oq.push_back(n ? q1.pop_front() : q0.pop_front());
          end
          n = !n;
        end
        lines_out++;
        {s0, s1, sk} = '0;
      end
      // Own timing: one pixel a clock
      pix_valid_out = oq.size() > 0;
      if (oq.size() > 0) pix_data_out = oq.pop_front();
    end
  end
endmodule

// ==== tb.sv ====
`timescale 1ns/1ps
`define DLM_CHK(a, b) begin comparisons++; if ((a) !== (b)) begin err_total++; \
  $display("[ERR] t=%0t got=%0h exp=%0h", $time, (a), (b)); end end
module tb;
  import dlm_pkg::*;
  typedef struct { dlm_cfg_s cfg; logic [11:0] n0; } dlm_row_s;
  logic             clk, link_clk, rst, line_start, px_valid, px_ready, line_busy, mv;
  logic [PIX_W-1:0] px_data, md;
  logic [15:0]      m_lines, m_errs;
  logic [11:0]      n0_cnt;
  dlm_cfg_s         line_cfg, dev_cfg;
  dlm_link_s        lk0, lk1;
  logic [PIX_W-1:0] got[$];
  dlm_row_s         rows[7];
  int               err_total, comparisons, cyc_cnt;

  // ----------------------------------------------------------------
  // Clocks, design and device model
  // ----------------------------------------------------------------
  initial clk = 1'b0;
  always #5 clk = ~clk;
  // Odd start offset keeps the two clocks out of phase
  initial begin
    link_clk = 1'b0;
    #2.3;
    forever #7.5 link_clk = ~link_clk;
  end

  dlm_host_splitter #(.LINE_PERIOD(96)) dut (
    .core_clk_in(clk), .link_clk_in(link_clk), .rst_in(rst),
    .line_start_in(line_start), .line_cfg_in(line_cfg), .px_valid_in(px_valid),
    .px_data_in(px_data), .px_ready_out(px_ready), .line_busy_out(line_busy),
    .input_link_zero_out(lk0), .input_link_one_out(lk1));

  dlm_dev_model model (
    .link_clk_in(link_clk), .rst_in(rst), .cfg_in(dev_cfg), .link0_in(lk0),
    .link1_in(lk1), .pix_valid_out(mv), .pix_data_out(md), .lines_out(m_lines),
    .errs_out(m_errs));

  // Collect merged pixels and link zero's share between link edges
  always @(negedge link_clk) begin
    if (mv === 1'b1) got.push_back(md);
    if (lk0.valid === 1'b1 && lk0.hss === 1'b0) n0_cnt <= n0_cnt + 12'h001;
  end

  // Guard against a hang; the full run needs about 1300 cycles
  always @(posedge clk) begin
    cyc_cnt++;
    if (cyc_cnt == 30000) begin
      err_total++;
      tally_and_finish();
    end
  end

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic dlm_row_s mk(input dlm_split_e m, input dlm_fmt_e f,
                                  input int g0, g1, sp, ln, n0);
    dlm_row_s row;
    row.cfg = '{m, f, 7'(g0), 7'(g1), 12'(sp), 12'(ln)};
    row.n0  = 12'(n0);
    return row;
  endfunction

  // Fits 16 bits so every packing carries it whole
  function automatic logic [PIX_W-1:0] pv(input int r, i);
    return {8'h00, r[3:0], i[11:0]};
  endfunction

  task automatic tally_and_finish();
    $display("errors=%0d comparisons=%0d", err_total, comparisons);
    if (err_total == 0 && comparisons > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // One line through the splitter and back out of the device model
  task automatic run_line(input dlm_row_s r, input int id, input bit stall, input bit poke);
    int  i, w, k;
    bit  taken;
    logic [15:0] l0;
    {i, w} = '0;
    l0 = m_lines;
    dev_cfg = r.cfg;
    got.delete();
    n0_cnt = 12'h000;
    line_cfg = r.cfg;
    line_start = 1'b1;
    @(negedge clk);
    line_start = 1'b0;
    // Ready is registered, so its level now is what the next edge sees
    while (i < int'(r.cfg.len)) begin
      px_data = pv(id, i);
      px_valid = !(stall && w[0]);
      w++;
      taken = px_valid && px_ready === 1'b1;
      @(negedge clk);
      if (taken) i++;
    end
    px_valid = 1'b0;
    `DLM_CHK(line_busy, 1'b1) // held while the line drains
    if (poke) begin
      line_cfg = rows[0].cfg;
      line_start = 1'b1;
      @(negedge clk);
      line_start = 1'b0;
    end
    while (line_busy !== 1'b0) @(negedge clk);
    while (got.size() < int'(r.cfg.len)) @(negedge clk);
    repeat (6) @(negedge clk);
    `DLM_CHK(got.size(), int'(r.cfg.len)) // one line only
    for (k = 0; k < got.size(); k++) `DLM_CHK(got[k], pv(id, k)) // order
    `DLM_CHK(n0_cnt, r.n0) // link zero share
    `DLM_CHK(m_lines, l0 + 16'h0001) // a line per start
    `DLM_CHK(m_errs, 16'h0000) // start skew and framing
    if (poke) `DLM_CHK(line_busy, 1'b0) // start while busy ignored
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    {err_total, comparisons, cyc_cnt} = '0;
    rst = 1'b1;
    {line_start, px_valid, px_data, line_cfg, dev_cfg} = '0;
    rows[0] = mk(DLM_SPLIT_HALVES, DLM_FMT_RGB565, 1, 1, 10, 24, 10);
    rows[1] = mk(DLM_SPLIT_HALVES, DLM_FMT_RGB888, 1, 1, 24, 24, 24);
    rows[2] = mk(DLM_SPLIT_HALVES, DLM_FMT_RGB666, 1, 1, 0, 20, 0);
    rows[3] = mk(DLM_SPLIT_GROUPS, DLM_FMT_YCC422, 1, 1, 0, 9, 5);
    rows[4] = mk(DLM_SPLIT_GROUPS, DLM_FMT_RGB888, 64, 64, 0, 70, 64);
    rows[5] = mk(DLM_SPLIT_GROUPS, DLM_FMT_RGB565, 3, 5, 0, 20, 9);
    rows[6] = mk(DLM_SPLIT_GROUPS, DLM_FMT_RGB666, 2, 1, 0, 7, 5);
    repeat (10) @(negedge clk);
    rst = 1'b0;
    repeat (2) @(negedge clk);
    foreach (rows[r]) run_line(rows[r], r, r[0], 1'b0);
    // Stalling source, and a start offered while busy
    run_line(rows[5], 9, 1'b1, 1'b1);
    // A zero-length line is refused
    line_cfg = '0;
    line_start = 1'b1;
    @(negedge clk);
    line_start = 1'b0;
    @(negedge clk);
    `DLM_CHK(line_busy, 1'b0) // no line without pixels
    // Reset in mid-line must clear both sides at once
    line_cfg = rows[0].cfg;
    line_start = 1'b1;
    @(negedge clk);
    line_start = 1'b0;
    px_valid = 1'b1;
    repeat (5) @(negedge clk);
    rst = 1'b1;
    px_valid = 1'b0;
    #1;
    `DLM_CHK(line_busy, 1'b0)
    `DLM_CHK(px_ready, 1'b0)
    `DLM_CHK(lk0.valid | lk1.valid, 1'b0) // links quiet
    repeat (10) @(negedge clk);
    rst = 1'b0;
    repeat (2) @(negedge clk);
    run_line(rows[3], 11, 1'b0, 1'b0);
    tally_and_finish();
  end
endmodule
